// File: verilog/vff_config_regs.sv
// feedback ratio, output floor and turn-on threshold command registers with floor clamp
`timescale 1ns/100ps
module vff_config_regs
	import vff_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_srst,
	input  wire logic        i_cmd_wr,
	input  wire logic        i_cmd_rd,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic [15:0] i_cmd_wdata,
	output logic      [15:0] o_cmd_rdata,
	output logic             o_cmd_ack,
	output logic             o_cmd_nack,
	input  wire logic        i_loop_slave,
	input  wire logic        i_output_on,
	input  wire logic        i_target_change,
	input  wire logic [15:0] i_target_ref,
	input  wire logic [15:0] i_max_ref,
	input  wire logic [10:0] i_vin_off_mant,
	input  wire logic        i_store_all,
	output logic      [15:0] o_ref_mant,
	output logic      [15:0] o_floor_ref,
	output logic             o_clamp_other_set,
	output logic             o_clamp_vfw_set,
	output logic             o_clamp_maxmin_set,
	output logic             o_cml_set,
	output logic             o_ivd_set,
	output logic             o_ivc_set,
	output logic             o_alert_set,
	output logic             o_nvm_store,
	output logic      [15:0] o_nvm_input_turn_on_threshold
);
	logic [2:0]  ratio_r;
	logic [11:0] floor_r;
	logic [3:0]  input_turn_on_threshold_r;
	logic        on_d_r;
	logic        check_r;
	logic [15:0] ref_r;
	logic [15:0] rdata_r;
	logic        ack_r;
	logic        nack_r;
	logic        other_r;
	logic        ivd_r;
	logic        ivc_r;
	logic        nvm_r;
	logic [15:0] nvm_data_r;

	// range of the floor mantissa for the ratio in force
	wire logic [11:0] min_lo_w = (ratio_r == VFF_RATIO_HALF)    ? VFF_MIN_LO_HALF :
	                             (ratio_r == VFF_RATIO_QUARTER) ? VFF_MIN_LO_QUART : VFF_MIN_LO_ONE;
	wire logic [11:0] min_hi_w = (ratio_r == VFF_RATIO_HALF)    ? VFF_MIN_HI_HALF :
	                             (ratio_r == VFF_RATIO_QUARTER) ? VFF_MIN_HI_QUART : VFF_MIN_HI_ONE;

	// floor in reference units: mantissa times ratio mantissa, quarter steps
	wire logic [15:0] floor_prod_w = 16'(floor_r) * 16'(ratio_r);
	wire logic [15:0] floor_ref_w  = floor_prod_w >> VFF_RATIO_SHIFT;

	// command decode
	wire logic        on_rise_w  = i_output_on & ~on_d_r;
	wire logic        hit_ratio  = i_cmd_code == VFF_CMD_RATIO;
	wire logic        hit_floor  = i_cmd_code == VFF_CMD_FLOOR;
	wire logic        hit_input_turn_on_threshold = i_cmd_code == VFF_CMD_INPUT_TURN_ON_THRESHOLD;
	wire logic        req_w      = i_cmd_wr | i_cmd_rd;
	wire logic        slave_ref_w = req_w & hit_floor & i_loop_slave;
	wire logic        unmapped_w = req_w & ~(hit_ratio | hit_floor | hit_input_turn_on_threshold);

	// ratio write: only the three legal mantissas pass
	wire logic [10:0] wr_mant_w   = i_cmd_wdata[10:0];
	wire logic        ratio_ok_w  = (wr_mant_w == 11'(VFF_RATIO_ONE)) | (wr_mant_w == 11'(VFF_RATIO_HALF)) |
	                                (wr_mant_w == 11'(VFF_RATIO_QUARTER));
	wire logic        ratio_wr_w  = i_cmd_wr & hit_ratio;
	wire logic        ratio_new_w = ratio_wr_w & ratio_ok_w;
	wire logic [11:0] ratio_def_w = (wr_mant_w[2:0] == VFF_RATIO_HALF)    ? VFF_MIN_LO_HALF :
	                                (wr_mant_w[2:0] == VFF_RATIO_QUARTER) ? VFF_MIN_LO_QUART : VFF_MIN_LO_ONE;

	// floor write: low twelve bits only, checked against the ratio range
	wire logic        floor_wr_w  = i_cmd_wr & hit_floor & ~i_loop_slave;
	wire logic [11:0] floor_in_w  = i_cmd_wdata[11:0];
	wire logic        floor_ok_w  = (floor_in_w >= min_lo_w) & (floor_in_w <= min_hi_w);
	wire logic        floor_new_w = floor_wr_w & floor_ok_w;

	// turn-on write: linear word turned into quarter-volt units with round-half-up
	wire logic signed [4:0]  wr_exp_w  = signed'(i_cmd_wdata[15:11]);
	wire logic signed [10:0] wr_sman_w = signed'(i_cmd_wdata[10:0]);
	wire logic signed [6:0]  up_sh_w   = 7'(wr_exp_w) + 7'sd2;
	wire logic [5:0]  dn_sh_w  = (up_sh_w < 0) ? 6'(-up_sh_w) : 6'h00;
	wire logic [5:0]  dn_lim_w = (dn_sh_w > VFF_SHIFT_MAX) ? VFF_SHIFT_MAX : dn_sh_w;
	wire logic [5:0]  up_lim_w = (up_sh_w > 7'(VFF_SHIFT_MAX)) ? VFF_SHIFT_MAX :
	                             ((up_sh_w > 0) ? 6'(up_sh_w) : 6'h00);
	wire logic signed [31:0] man_ext_w = 32'(wr_sman_w);
	wire logic signed [31:0] half_w    = (dn_lim_w == 6'h00) ? 32'sd0 : (32'sd1 <<< (dn_lim_w - 6'h01));
	wire logic signed [31:0] quart_w   = (up_sh_w < 0) ? ((man_ext_w + half_w) >>> dn_lim_w)
	                                                   : (man_ext_w <<< up_lim_w);
	wire logic        vin_rng_ok_w = (quart_w >= 32'(VFF_INPUT_TURN_ON_THRESHOLD_LO)) & (quart_w <= 32'(VFF_INPUT_TURN_ON_THRESHOLD_HI));
	wire logic        vin_ord_ok_w = quart_w > 32'(i_vin_off_mant);
	wire logic        vin_wr_w     = i_cmd_wr & hit_input_turn_on_threshold;
	wire logic        vin_new_w    = vin_wr_w & vin_rng_ok_w & vin_ord_ok_w;
	wire logic        vin_bad_w    = vin_wr_w & ~(vin_rng_ok_w & vin_ord_ok_w);

	// any rejected data write raises the invalid-data pulse
	wire logic        bad_data_w = (ratio_wr_w & ~ratio_ok_w) |
	                               (floor_wr_w & ~floor_ok_w) |
	                               vin_bad_w;

	// read-back words with fixed fields
	wire logic [15:0] ratio_word_w  = {VFF_EXP_QUARTER, 8'h00, ratio_r};
	wire logic [15:0] floor_word_w  = {4'h0, floor_r};
	wire logic [15:0] input_turn_on_threshold_word_w = {VFF_EXP_QUARTER, VFF_INPUT_TURN_ON_THRESHOLD_FIXED, input_turn_on_threshold_r};
	wire logic [15:0] rd_mux_w      = hit_ratio ? ratio_word_w :
	                                  hit_floor ? floor_word_w :
	                                  input_turn_on_threshold_word_w;

	// clamp decision; maximum dominates a floor above it
	wire logic        max_wins_w  = i_max_ref < floor_ref_w;
	wire logic        below_w     = i_target_ref < floor_ref_w;
	wire logic        clamp_w     = check_r & i_output_on & below_w & ~max_wins_w;
	wire logic [15:0] ref_nxt     = max_wins_w ? i_max_ref :
	                                below_w    ? floor_ref_w :
	                                i_target_ref;
	wire logic        check_nxt   = i_target_change | ratio_new_w |
	                                floor_new_w | on_rise_w;

	// bus answer and register load terms
	// an out-of-range floor found at switch-on is reloaded to the ratio minimum
	wire logic        floor_fix_w = on_rise_w &
	                                ((floor_r < min_lo_w) | (floor_r > min_hi_w));
	wire logic [15:0] ref_sel_w   = i_output_on ? ref_nxt : i_target_ref;
	wire logic        refused_w   = slave_ref_w | unmapped_w;
	wire logic [15:0] rdata_nxt   = (i_cmd_rd & ~refused_w) ?
	                                rd_mux_w : 16'h0000;
	wire logic        ack_nxt     = req_w & ~refused_w;

	// ratio changes only on a legal mantissa
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			ratio_r <= VFF_RATIO_ONE;
		else if (ratio_new_w)
			ratio_r <= wr_mant_w[2:0];
	end

	// a legal ratio write reloads the floor, since the old mantissa may fall outside the new range
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			floor_r <= VFF_MIN_LO_ONE;
		else if (ratio_new_w)
			floor_r <= ratio_def_w;
		else if (floor_fix_w)
			floor_r <= min_lo_w;
		else if (floor_new_w)
			floor_r <= floor_in_w;
	end

	// turn-on mantissa keeps only its four writable bits
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			input_turn_on_threshold_r <= VFF_INPUT_TURN_ON_THRESHOLD_RST;
		else if (vin_new_w)
			input_turn_on_threshold_r <= quart_w[3:0];
	end

	// previous output-on level for switch-on detection
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			on_d_r <= 1'b0;
		else
			on_d_r <= i_output_on;
	end

	// a check is pending right after reset so ref starts from the target
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			check_r <= 1'b1;
		else
			check_r <= check_nxt;
	end

	// ref loads only in a cycle with a check pending: after reset, a target change, an accepted ratio or floor write, or switch-on
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			ref_r <= 16'h0000;
		else if (check_r)
			ref_r <= ref_sel_w;
	end

	// read word is zero outside the ack cycle
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			rdata_r <= 16'h0000;
		else
			rdata_r <= rdata_nxt;
	end

	// writes are acked even when their data is rejected
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			ack_r <= 1'b0;
		else
			ack_r <= ack_nxt;
	end

	// refused access: unmapped code or floor while loop slave
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			nack_r <= 1'b0;
		else
			nack_r <= refused_w;
	end

	// flag pulses last one cycle; sticky status bits live outside
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			other_r <= 1'b0;
		else
			other_r <= clamp_w;
	end

	// invalid data pulse
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			ivd_r <= 1'b0;
		else
			ivd_r <= bad_data_w;
	end

	// invalid command pulse
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			ivc_r <= 1'b0;
		else
			ivc_r <= refused_w;
	end

	// store strobe one cycle after the store-all command
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			nvm_r <= 1'b0;
		else
			nvm_r <= i_store_all;
	end

	// stored word resampled every cycle from the turn-on read word
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			nvm_data_r <= 16'h0000;
		else
			nvm_data_r <= input_turn_on_threshold_word_w;
	end

	// outputs straight from flip-flops, except the floor in reference units and the ORed alert
	assign o_cmd_rdata        = rdata_r;
	assign o_cmd_ack          = ack_r;
	assign o_cmd_nack         = nack_r;
	assign o_ref_mant         = ref_r;
	assign o_floor_ref        = floor_ref_w;
	assign o_clamp_other_set  = other_r;
	assign o_clamp_vfw_set    = other_r;
	assign o_clamp_maxmin_set = other_r;
	assign o_cml_set          = ivd_r;
	assign o_ivd_set          = ivd_r;
	assign o_ivc_set          = ivc_r;
	assign o_alert_set        = other_r | ivd_r | ivc_r;
	assign o_nvm_store        = nvm_r;
	assign o_nvm_input_turn_on_threshold       = nvm_data_r;
endmodule : vff_config_regs

// File: verilog/vff_pkg.sv
// constants for the output floor, feedback ratio and turn-on threshold command registers
package vff_pkg;
	localparam logic [7:0]  VFF_CMD_RATIO     = 8'h29;
	localparam logic [7:0]  VFF_CMD_FLOOR     = 8'h2B;
	localparam logic [7:0]  VFF_CMD_INPUT_TURN_ON_THRESHOLD    = 8'h35;
	localparam logic [4:0]  VFF_EXP_QUARTER   = 5'h1E;
	localparam logic [2:0]  VFF_RATIO_ONE     = 3'h4;
	localparam logic [2:0]  VFF_RATIO_HALF    = 3'h2;
	localparam logic [2:0]  VFF_RATIO_QUARTER = 3'h1;
	localparam logic [11:0] VFF_MIN_LO_ONE    = 12'h0B3;
	localparam logic [11:0] VFF_MIN_HI_ONE    = 12'h300;
	localparam logic [11:0] VFF_MIN_LO_HALF   = 12'h166;
	localparam logic [11:0] VFF_MIN_HI_HALF   = 12'h600;
	localparam logic [11:0] VFF_MIN_LO_QUART  = 12'h2CC;
	localparam logic [11:0] VFF_MIN_HI_QUART  = 12'hC00;
	localparam logic [10:0] VFF_INPUT_TURN_ON_THRESHOLD_LO     = 11'h011;
	localparam logic [10:0] VFF_INPUT_TURN_ON_THRESHOLD_HI     = 11'h01F;
	localparam logic [3:0]  VFF_INPUT_TURN_ON_THRESHOLD_RST    = 4'h2;
	localparam logic [6:0]  VFF_INPUT_TURN_ON_THRESHOLD_FIXED  = 7'h01;
	localparam int          VFF_RATIO_SHIFT   = 2;
	localparam logic [5:0]  VFF_SHIFT_MAX     = 6'h0F;
endpackage : vff_pkg

// File: testbench/vff_config_sva.sv
// assertions on the config register ports
`timescale 1ns/100ps
module vff_config_sva
	import vff_pkg::*;
(
	input wire logic        i_ref_clk,
	input wire logic        i_srst,
	input wire logic        i_cmd_wr,
	input wire logic        i_cmd_rd,
	input wire logic [7:0]  i_cmd_code,
	input wire logic        i_loop_slave,
	input wire logic [15:0] o_cmd_rdata,
	input wire logic        o_cmd_ack,
	input wire logic        o_cmd_nack,
	input wire logic [15:0] o_ref_mant,
	input wire logic [15:0] o_floor_ref,
	input wire logic        o_clamp_other_set,
	input wire logic        o_clamp_vfw_set,
	input wire logic        o_clamp_maxmin_set,
	input wire logic        o_cml_set,
	input wire logic        o_ivd_set,
	input wire logic        o_ivc_set,
	input wire logic        o_alert_set
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	sequence s_slave_floor; (i_cmd_wr || i_cmd_rd) && i_loop_slave && i_cmd_code == VFF_CMD_FLOOR; endsequence
	sequence s_refused; o_cmd_nack && o_ivc_set && o_alert_set && !o_cmd_ack; endsequence
	sequence s_rd(logic [7:0] c); i_cmd_rd && i_cmd_code == c; endsequence
	a_slave_floor_nack: assert property (s_slave_floor |=> s_refused) else $error("slave floor access kept");
	a_ratio_exp_fixed: assert property (s_rd(VFF_CMD_RATIO) |=> o_cmd_rdata[15:11] == 5'h1E) else $error("ratio exp");
	a_ratio_mant_legal: assert property (s_rd(VFF_CMD_RATIO) |=> o_cmd_rdata[10:0] inside {11'h1, 11'h2, 11'h4})
		else $error("ratio mantissa illegal");
	a_floor_top_zero: assert property (s_rd(VFF_CMD_FLOOR) && !i_loop_slave |=> o_cmd_ack && o_cmd_rdata[15:12] == 4'h0)
		else $error("floor top bits set");
	a_input_turn_on_threshold_fixed: assert property (s_rd(VFF_CMD_INPUT_TURN_ON_THRESHOLD) |=> o_cmd_rdata[15:4] == 12'hF01) else $error("turn-on fixed");
	a_clamp_to_floor: assert property (o_clamp_other_set |-> o_ref_mant == o_floor_ref) else $error("ref not floor");
	a_clamp_flags_all: assert property (o_clamp_other_set |-> o_clamp_vfw_set && o_clamp_maxmin_set && o_alert_set)
		else $error("clamp flags incomplete");
	a_bad_data_flags: assert property (o_cml_set |-> $past(i_cmd_wr) && o_ivd_set && o_alert_set)
		else $error("bad data flags");
endmodule : vff_config_sva
bind vff_config_regs vff_config_sva u_sva (.*);

// File: testbench/vff_host_model.sv
// host model issuing single word command transfers
`timescale 1ns/100ps
module vff_host_model
(
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_ack,
	input  wire logic        i_nack,
	output logic             o_wr,
	output logic             o_rd,
	output logic      [7:0]  o_code,
	output logic      [15:0] o_wdata
);
	initial {o_wr, o_rd, o_code, o_wdata} = '0;
	task xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q, output logic a,
		output logic n);
		@(posedge i_clk);
		#1 {o_wr, o_rd, o_code, o_wdata} = {w, !w, c, d};
		@(posedge i_clk);
		// released data shows the inverse so a stale word never passes for a good one
		#1 {o_wr, o_rd, o_wdata} = {2'b00, ~d};
		{q, a, n} = {i_rdata, i_ack, i_nack};
	endtask : xfer
endmodule : vff_host_model

// File: testbench/testbench.sv
// self-checking bench for the ratio, floor and turn-on threshold registers
`timescale 1ns/100ps
`define CHK(s, e, v) begin samples_checked++; if ((v) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", s, e, v); end end
module testbench;
	import vff_pkg::*;
	logic clk = 0, srst = 1, slave = 0, on = 0, tchg = 0, store = 0, wr, rd, ack, nack, a, n, oth, cml, nst, alert;
	logic [15:0] tref = 16'd500, mref = 16'd1000, wdata, rdata, ref_m, nvin, q, fref;
	logic [10:0] voff = 11'd16;
	logic [7:0] code;
	logic [11:0] lo [3] = '{12'h0B3, 12'h166, 12'h2CC};
	logic [11:0] hi [3] = '{12'h300, 12'h600, 12'hC00};
	logic [2:0] rm [3] = '{3'h4, 3'h2, 3'h1};
	int fails = 0, samples_checked = 0, cml_n = 0, clamp_n = 0, alert_n = 0, cyc = 0, c0;
	vff_host_model h (.i_clk(clk), .i_rdata(rdata), .i_ack(ack), .i_nack(nack), .o_wr(wr), .o_rd(rd), .o_code(code),
		.o_wdata(wdata));
	vff_config_regs DUT (.i_ref_clk(clk), .i_srst(srst), .i_cmd_wr(wr), .i_cmd_rd(rd), .i_cmd_code(code),
		.i_cmd_wdata(wdata), .o_cmd_rdata(rdata), .o_cmd_ack(ack), .o_cmd_nack(nack), .i_loop_slave(slave),
		.i_output_on(on), .i_target_change(tchg), .i_target_ref(tref), .i_max_ref(mref), .i_vin_off_mant(voff),
		.i_store_all(store), .o_ref_mant(ref_m), .o_floor_ref(fref), .o_clamp_other_set(oth), .o_clamp_vfw_set(),
		.o_clamp_maxmin_set(), .o_cml_set(cml), .o_ivd_set(), .o_ivc_set(), .o_alert_set(alert), .o_nvm_store(nst),
		.o_nvm_input_turn_on_threshold(nvin));
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cml === 1'b1) cml_n++;
		if (oth === 1'b1) clamp_n++;
		if (alert === 1'b1) alert_n++;
		// ceiling is about twenty-four times the length of the planned sequence
		if (cyc == 3000)
		begin
			fails++;
			conclude();
		end
	end
	task automatic w(input logic [7:0] c, input logic [15:0] d, input logic bad);
		int k = cml_n;
		int ka = alert_n;
		h.xfer(1'b1, c, d, q, a, n);
		repeat (2) @(posedge clk);
		#1 `CHK("write ack", 1'b1, a)
		`CHK("data refused", bad, 1'(cml_n != k))
		`CHK("alert", bad, 1'(alert_n != ka))
	endtask : w
	task automatic r(input logic [7:0] c, input logic [15:0] e, input logic nk);
		h.xfer(1'b0, c, 16'h0, q, a, n);
		`CHK("nack", nk, n)
		`CHK("read word", e, q)
	endtask : r
	task automatic pulse_target(input logic [15:0] e);
		@(posedge clk);
		#1 tchg = 1;
		@(posedge clk);
		#1 tchg = 0;
		@(posedge clk);
		#1 `CHK("reference", e, ref_m)
	endtask : pulse_target
	task conclude;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (4) @(posedge clk);
		#1 srst = 0;
		r(VFF_CMD_RATIO, 16'hF004, 0);
		r(VFF_CMD_FLOOR, 16'h00B3, 0);
		r(VFF_CMD_INPUT_TURN_ON_THRESHOLD, 16'hF012, 0);
		w(VFF_CMD_RATIO, 16'h0003, 1);
		r(VFF_CMD_RATIO, 16'hF004, 0);
		for (int i = 2; i >= 0; i--)
		begin
			w(VFF_CMD_RATIO, {13'h0, rm[i]}, 0);
			r(VFF_CMD_RATIO, {5'h1E, 8'h0, rm[i]}, 0);
			r(VFF_CMD_FLOOR, {4'h0, lo[i]}, 0);
			w(VFF_CMD_FLOOR, {4'hF, hi[i]}, 0);
			r(VFF_CMD_FLOOR, {4'h0, hi[i]}, 0);
			w(VFF_CMD_FLOOR, {4'h0, hi[i] + 12'h1}, 1);
			w(VFF_CMD_FLOOR, {4'h0, lo[i] - 12'h1}, 1);
		end
		w(VFF_CMD_FLOOR, 16'h00B3, 0);
		$display("ratio and floor test done");
		w(VFF_CMD_INPUT_TURN_ON_THRESHOLD, 16'hF011, 0);
		w(VFF_CMD_INPUT_TURN_ON_THRESHOLD, 16'hF020, 1);
		r(VFF_CMD_INPUT_TURN_ON_THRESHOLD, 16'hF011, 0);
		w(VFF_CMD_INPUT_TURN_ON_THRESHOLD, 16'hE825, 0);
		r(VFF_CMD_INPUT_TURN_ON_THRESHOLD, 16'hF013, 0);
		voff = 11'd19;
		w(VFF_CMD_INPUT_TURN_ON_THRESHOLD, 16'hF013, 1);
		@(posedge clk);
		#1 store = 1;
		@(posedge clk);
		#1 store = 0;
		`CHK("store strobe", 1'b1, nst)
		`CHK("stored word", 16'hF013, nvin)
		$display("turn-on threshold test done");
		on = 1;
		pulse_target(16'd500);
		c0 = clamp_n;
		tref = 16'd100;
		pulse_target(16'h00B3);
		`CHK("floor ref", 16'h00B3, fref)
		repeat (2) @(posedge clk);
		#1 `CHK("clamp flagged", 1, clamp_n - c0)
		mref = 16'd100;
		pulse_target(16'd100);
		slave = 1;
		r(VFF_CMD_FLOOR, 16'h0000, 1);
		h.xfer(1'b1, VFF_CMD_FLOOR, 16'h0200, q, a, n);
		`CHK("slave write nack", 1'b1, n)
		slave = 0;
		r(VFF_CMD_FLOOR, 16'h00B3, 0);
		$display("clamp and slave test done");
		conclude();
	end
endmodule : testbench
